/* File: design/apms_cfg_if.sv */
// Interface carrying the pin mode vector between modules
`timescale 1ns/1ns
interface apms_cfg_if;
	logic [23:0] digital;
	modport src (output digital);
	modport dst (input digital);
endinterface

/* File: design/apms_pin_path.sv */
// Per-pin read gating and converter input selection
`timescale 1ns/1ns
module apms_pin_path
	import apms_pkg::*;
(
	input wire logic mclk,
	input wire logic resetn,
	apms_cfg_if.dst cfg,
	input wire logic [23:0] pin_sync,
	input wire logic [4:0] channel_select,
	output logic [23:0] port_read,
	output logic converter_sample
);
	logic [23:0] next_port_read;

	genvar i;
	generate
		for (i = 0; i < APMS_PINS; i = i + 1)
		begin : g_pin
			// Analog pins read zero so the port never shows a stray level
			assign next_port_read[i] = cfg.digital[i] & pin_sync[i];
		end
	endgenerate

	always_ff @(posedge mclk)
	begin
		if (!resetn)
			port_read <= 24'h000000;
		else
			port_read <= next_port_read;
	end

	// Out-of-range channel reads ground, same as a digital pin
	always_ff @(posedge mclk)
	begin
		if (!resetn)
			converter_sample <= 1'b0;
		else if (channel_select >= 5'(APMS_PINS))
			converter_sample <= 1'b0;
		else if (cfg.digital[channel_select])
			converter_sample <= 1'b0;
		else
			converter_sample <= pin_sync[channel_select];
	end
endmodule

/* File: design/apms_pkg.sv */
// Package of constants for the analog pin mode select block
package apms_pkg;
	localparam logic [3:0] APMS_ADDR_LOW = 4'h0;
	localparam logic [3:0] APMS_ADDR_HIGH = 4'h4;
	localparam logic [15:0] APMS_LOW_RESET = 16'h0000;
	localparam logic [7:0] APMS_HIGH_RESET = 8'h00;
	localparam int APMS_LOW_BITS = 16;
	localparam int APMS_HIGH_BITS = 8;
	localparam int APMS_PINS = 24;
endpackage

/* File: design/apms_top.sv */
// Top of the analog pin mode select block with register port
//
// The register addresses and the strobed register port are this design's own decisions.
`timescale 1ns/1ns
module apms_top
	import apms_pkg::*;
#(
	parameter int LOW_BITS = APMS_LOW_BITS,
	parameter int HIGH_BITS = APMS_HIGH_BITS
)
(
	input wire logic mclk,
	input wire logic resetn,
	input wire logic [3:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	output logic [15:0] reg_rdata,
	input wire logic [23:0] pin_level,
	input wire logic [4:0] channel_select,
	output logic [23:0] port_read,
	output logic converter_sample,
	output logic [23:0] pin_digital
);
	logic [15:0] pin_digital_select_low;
	logic [7:0] pin_digital_select_high;
	logic [23:0] pin_meta;
	logic [23:0] pin_sync;
	apms_cfg_if cfg ();

	// Ports and carrier are fixed at the documented split, refuse others
	generate
		if (LOW_BITS != APMS_LOW_BITS || HIGH_BITS != APMS_HIGH_BITS)
		begin : g_bad_split
			$error("pin split not supported");
		end
		if (LOW_BITS + HIGH_BITS != APMS_PINS)
		begin : g_bad_count
			$error("pin count mismatch");
		end
	endgenerate

	// Pins are asynchronous; first stage feeds only the second
	always_ff @(posedge mclk)
	begin
		if (!resetn)
		begin
			pin_meta <= 24'h000000;
			pin_sync <= 24'h000000;
		end
		else
		begin
			pin_meta <= pin_level;
			pin_sync <= pin_meta;
		end
	end

	always_ff @(posedge mclk)
	begin
		if (!resetn)
			pin_digital_select_low <= APMS_LOW_RESET;
		else if (reg_write && reg_addr == APMS_ADDR_LOW)
			pin_digital_select_low <= reg_wdata;
	end

	always_ff @(posedge mclk)
	begin
		if (!resetn)
			pin_digital_select_high <= APMS_HIGH_RESET;
		else if (reg_write && reg_addr == APMS_ADDR_HIGH)
			pin_digital_select_high <= reg_wdata[7:0];
	end

	always_ff @(posedge mclk)
	begin
		if (!resetn)
			reg_rdata <= 16'h0000;
		else if (reg_read)
		begin
			case (reg_addr)
				APMS_ADDR_LOW: reg_rdata <= pin_digital_select_low;
				APMS_ADDR_HIGH: reg_rdata <= {8'h00, pin_digital_select_high};
				default: reg_rdata <= 16'h0000;
			endcase
		end
		else
			reg_rdata <= 16'h0000;
	end

	assign cfg.digital = {pin_digital_select_high, pin_digital_select_low};

	always_ff @(posedge mclk)
	begin
		if (!resetn)
			pin_digital <= 24'h000000;
		else
			pin_digital <= cfg.digital;
	end

	apms_pin_path u_path (
		.mclk(mclk),
		.resetn(resetn),
		.cfg(cfg),
		.pin_sync(pin_sync),
		.channel_select(channel_select),
		.port_read(port_read),
		.converter_sample(converter_sample)
	);

	chk_high_upper_zero: assert property (
		@(posedge mclk) disable iff (!resetn)
		$past(reg_read) && $past(reg_addr) == APMS_ADDR_HIGH
		|-> reg_rdata[15:8] == 8'h00
		) else $error("upper byte not zero");
	chk_low_write_read: assert property (
		@(posedge mclk) disable iff (!resetn)
		reg_write && reg_addr == APMS_ADDR_LOW ##1 reg_read
		&& reg_addr == APMS_ADDR_LOW && !reg_write
		|=> reg_rdata == $past(reg_wdata, 2)
		) else $error("low readback wrong");
	chk_analog_read_zero: assert property (
		@(posedge mclk) disable iff (!resetn)
		(port_read & ~pin_digital) == 24'h000000
		) else $error("analog pin seen on port");
	chk_digital_read_pin: assert property (
		@(posedge mclk) disable iff (!resetn)
		resetn |=> port_read == ($past(cfg.digital) & $past(pin_sync))
		) else $error("digital pin not read");
	chk_reset_analog: assert property (
		@(posedge mclk)
		!resetn |=> pin_digital_select_low == 16'h0000
		&& pin_digital_select_high == 8'h00
		) else $error("reset not analog");
	chk_reset_outputs: assert property (
		@(posedge mclk)
		!resetn |=> port_read == 24'h000000 && pin_digital == 24'h000000
		&& !converter_sample && reg_rdata == 16'h0000
		) else $error("outputs not cleared by reset");
	chk_digital_ground: assert property (
		@(posedge mclk) disable iff (!resetn)
		channel_select < 5'h18 && cfg.digital[channel_select]
		|=> !converter_sample
		) else $error("digital channel not grounded");
	chk_analog_sample: assert property (
		@(posedge mclk) disable iff (!resetn)
		channel_select < 5'h18 && !cfg.digital[channel_select]
		|=> converter_sample == $past(pin_sync[channel_select])
		) else $error("analog sample wrong");
	chk_unmapped_zero: assert property (
		@(posedge mclk) disable iff (!resetn)
		reg_read && reg_addr != APMS_ADDR_LOW && reg_addr != APMS_ADDR_HIGH
		|=> reg_rdata == 16'h0000
		) else $error("unmapped read not zero");

	chk_low_write_take: assert property (
		@(posedge mclk) disable iff (!resetn)
		reg_write && reg_addr == APMS_ADDR_LOW
		|=> pin_digital_select_low == $past(reg_wdata)
		) else $error("low write not taken");
	chk_high_write_mask: assert property (
		@(posedge mclk) disable iff (!resetn)
		reg_write && reg_addr == APMS_ADDR_HIGH
		|=> pin_digital_select_high == $past(reg_wdata[7:0])
		) else $error("high write not masked");
	chk_low_hold: assert property (
		@(posedge mclk) disable iff (!resetn)
		!(reg_write && reg_addr == APMS_ADDR_LOW)
		|=> $stable(pin_digital_select_low)
		) else $error("low register changed without write");
	chk_high_hold: assert property (
		@(posedge mclk) disable iff (!resetn)
		!(reg_write && reg_addr == APMS_ADDR_HIGH)
		|=> $stable(pin_digital_select_high)
		) else $error("high register changed without write");

	chk_low_readback: assert property (
		@(posedge mclk) disable iff (!resetn)
		reg_read && reg_addr == APMS_ADDR_LOW
		|=> reg_rdata == $past(pin_digital_select_low)
		) else $error("low read data wrong");
	chk_high_readback: assert property (
		@(posedge mclk) disable iff (!resetn)
		reg_read && reg_addr == APMS_ADDR_HIGH
		|=> reg_rdata == {8'h00, $past(pin_digital_select_high)}
		) else $error("high read data wrong");
	chk_idle_rdata: assert property (
		@(posedge mclk) disable iff (!resetn)
		!reg_read
		|=> reg_rdata == 16'h0000
		) else $error("read data outside read cycle");

	chk_vector_mirror: assert property (
		@(posedge mclk) disable iff (!resetn)
		resetn
		|=> pin_digital == $past(cfg.digital)
		) else $error("pin vector not mirrored");
	chk_meta_only: assert property (
		@(posedge mclk) disable iff (!resetn)
		resetn
		|=> pin_sync == $past(pin_meta)
		) else $error("pin synchroniser skipped");
	chk_pin_two_stage: assert property (
		@(posedge mclk) disable iff (!resetn)
		$past(resetn) && $past(resetn, 2) && $past(resetn, 3)
		|-> port_read
		== ($past(cfg.digital) & $past(pin_level, 3))
		) else $error("port read latency wrong");
	chk_range_ground: assert property (
		@(posedge mclk) disable iff (!resetn)
		channel_select >= 5'h18
		|=> !converter_sample
		) else $error("out of range channel not grounded");

	// One mux check per channel keeps each failure tied to its pin
	genvar n;
	generate
		for (n = 0; n < APMS_PINS; n = n + 1)
		begin : g_chk
			chk_channel_mux: assert property (
				@(posedge mclk) disable iff (!resetn)
				channel_select == 5'(n) |=> converter_sample
				== (!$past(cfg.digital[n]) && $past(pin_sync[n]))
				) else $error("channel mux wrong");
		end
	endgenerate

	cov_digital_set: cover property (
		@(posedge mclk) disable iff (!resetn)
		reg_write && reg_addr == APMS_ADDR_LOW && reg_wdata != 16'h0000);
	cov_high_write: cover property (
		@(posedge mclk) disable iff (!resetn)
		reg_write && reg_addr == APMS_ADDR_HIGH && reg_wdata[15:8] != 8'h00);
	cov_analog_sample: cover property (
		@(posedge mclk) disable iff (!resetn)
		!cfg.digital[channel_select] && converter_sample);
	cov_back_to_back: cover property (
		@(posedge mclk) disable iff (!resetn)
		reg_write ##1 reg_read && reg_addr == APMS_ADDR_LOW);
	cov_ground_channel: cover property (
		@(posedge mclk) disable iff (!resetn)
		channel_select < 5'h18 && cfg.digital[channel_select]
		&& pin_sync[channel_select]);
endmodule

/* File: dv/apms_tb.sv */
// Self-checking bench for the analog pin mode select block
`timescale 1ns/1ns
module apms_tb;
	import apms_pkg::*;
	typedef struct {logic [3:0] a; logic [15:0] d, e;} apms_row_type;
	apms_row_type rows [5] = '{'{4'h0, 16'hFFFF, 16'hFFFF},
		'{4'h4, 16'hFFFF, 16'h00FF}, '{4'h0, 16'h0000, 16'h0000},
		'{4'h4, 16'h12A5, 16'h00A5}, '{4'h8, 16'hFFFF, 16'h0000}};
	logic mclk = 0, resetn = 0, reg_write = 0, reg_read = 0;
	logic [3:0] reg_addr = 4'h0;
	logic [15:0] reg_wdata = 16'h0000, reg_rdata, q;
	logic [23:0] pin_level = 24'h000000, port_read, pin_digital;
	logic [4:0] channel_select = 5'h00;
	logic converter_sample;
	int fail_count = 0, cmp_count = 0;
	always #20 mclk = ~mclk;
	apms_top i_apms_top (.mclk(mclk), .resetn(resetn), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
		.reg_rdata(reg_rdata), .pin_level(pin_level),
		.channel_select(channel_select), .port_read(port_read),
		.converter_sample(converter_sample), .pin_digital(pin_digital));
	task conclude;
		$display("compares %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task chk(input logic [23:0] s, input logic [23:0] e, input string n);
		cmp_count++;
		if (s !== e)
		begin
			fail_count++;
			$display("BAD %s exp %h seen %h", n, e, s);
		end
	endtask
	task wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge mclk);
		reg_write <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge mclk);
		reg_write <= 1'b0;
	endtask
	// Read data stand for one cycle only, so sample just after that edge
	task rd(input logic [3:0] a);
		@(posedge mclk);
		reg_read <= 1'b1;
		reg_addr <= a;
		@(posedge mclk);
		reg_read <= 1'b0;
		#1 q = reg_rdata;
	endtask
	// Write then read the same register with no idle cycle between
	task wrrd(input logic [3:0] a, input logic [15:0] d);
		@(posedge mclk);
		reg_write <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge mclk);
		reg_write <= 1'b0;
		reg_read <= 1'b1;
		@(posedge mclk);
		reg_read <= 1'b0;
		#1 q = reg_rdata;
	endtask
	task pick(input logic [4:0] ch, input logic e);
		@(posedge mclk);
		channel_select <= ch;
		repeat (2) @(posedge mclk);
		#1 chk(converter_sample, e, "sample");
	endtask
	initial
	begin
		repeat (5) @(posedge mclk);
		resetn <= 1'b1;
		rd(APMS_ADDR_HIGH);
		chk(q, 16'h0000, "high reset");
		foreach (rows[i])
		begin
			wr(rows[i].a, rows[i].d);
			rd(rows[i].a);
			chk(q, rows[i].e, "row");
		end
		wr(APMS_ADDR_LOW, 16'hA5A5);
		wr(APMS_ADDR_HIGH, 16'h005A);
		pin_level <= 24'hFFFFFF;
		repeat (4) @(posedge mclk);
		#1 chk(pin_digital, 24'h5AA5A5, "vector");
		chk(port_read, 24'h5AA5A5, "port");
		pick(5'h00, 1'b0);
		pick(5'h01, 1'b1);
		pick(5'h18, 1'b0);
		pick(5'h10, 1'b1);
		@(posedge mclk);
		pin_level <= 24'h0F0F0F;
		repeat (4) @(posedge mclk);
		#1 chk(port_read, 24'h0A0505, "port mask");
		pick(5'h11, 1'b0);
		pick(5'h04, 1'b0);
		wrrd(APMS_ADDR_LOW, 16'h3C3C);
		chk(q, 16'h3C3C, "low back to back");
		wrrd(APMS_ADDR_HIGH, 16'hFF3C);
		chk(q, 16'h003C, "high back to back");
		@(posedge mclk);
		resetn <= 1'b0;
		repeat (2) @(posedge mclk);
		resetn <= 1'b1;
		#1 chk(pin_digital, 24'h000000, "reset vector");
		rd(APMS_ADDR_LOW);
		chk(q, 16'h0000, "low reset");
		rd(APMS_ADDR_HIGH);
		chk(q, 16'h0000, "high reset again");
		chk(port_read, 24'h000000, "reset port");
		pick(5'h01, 1'b1);
		conclude;
	end
endmodule
